// File: hw/bcru_pkg.sv
// Package for the branch, call and return unit
package bcru_pkg;

	typedef enum logic [4:0] {
		OP_NOP    = 5'h00,
		OP_JBS    = 5'h01,
		OP_JBC    = 5'h02,
		OP_JBSC   = 5'h03,
		OP_JAZ    = 5'h04,
		OP_JANZ   = 5'h05,
		OP_CMPJ   = 5'h06,
		OP_DECJ   = 5'h07,
		OP_ABSOLUTE_JUMP   = 5'h08,
		OP_EXTENDED_JUMP   = 5'h09,
		OP_LONG_JUMP   = 5'h0A,
		OP_SHORT_JUMP   = 5'h0B,
		OP_IJMP   = 5'h0C,
		OP_ABSOLUTE_CALL  = 5'h0D,
		OP_EXTENDED_CALL  = 5'h0E,
		OP_LONG_CALL  = 5'h0F,
		OP_RET    = 5'h10,
		OP_EXTENDED_RETURN   = 5'h11,
		OP_IRET   = 5'h12,
		OP_TRAP   = 5'h13
	} bcru_op_t;

	// Operand form: short bit, 8-bit bit, indirect register, direct etc.
	typedef enum logic [1:0] {
		FM_SHORT  = 2'h0,
		FM_LONG   = 2'h1,
		FM_INDIR  = 2'h2,
		FM_REG    = 2'h3
	} bcru_form_t;

	typedef enum logic [1:0] {
		LOC_RAM   = 2'h0,
		LOC_PORT  = 2'h1,
		LOC_SFR   = 2'h2
	} bcru_loc_t;

	typedef struct packed {
		bcru_op_t   op;
		bcru_form_t form;
		bcru_loc_t  loc;
		logic [7:0] rel;
		logic [23:0] target;
		logic       opnd_bit;
		logic [7:0] opnd1;
		logic [7:0] opnd2;
	} bcru_req_t;

	typedef struct packed {
		logic [23:0] pc;
		logic        wr_bit;
		logic        wr_byte;
		logic [7:0]  wr_data;
		logic        wr_carry;
		logic        carry;
		logic        push;
		logic        pop;
		logic        stk_wide;
		logic        stk_psw;
		logic [4:0]  states;
		logic        taken;
	} bcru_rsp_t;

	localparam logic [7:0]  PC_PAGE_FF     = 8'hFF;
	localparam logic [23:0] TRAP_VEC_RST   = 24'hFF007B;
	localparam logic [4:0]  ST_TAKEN_ADD   = 5'h03;
	localparam logic [4:0]  ST_EXT_FRAME   = 5'h05;
	localparam logic [4:0]  ST_EXT_ABS     = 5'h02;
	localparam logic [4:0]  ST_EXT_OTHER   = 5'h03;
	localparam logic [4:0]  ST_ODD         = 5'h01;
	localparam logic [4:0]  ST_NOP         = 5'h01;
	localparam logic [4:0]  ST_SHORT_JUMP        = 5'h04;
	localparam logic [4:0]  ST_IJMP        = 5'h05;
	localparam logic [4:0]  ST_CALL        = 5'h09;
	localparam logic [4:0]  ST_RET         = 5'h07;
	localparam logic        MODE_RST       = 1'b0;

endpackage : bcru_pkg

// File: hw/bcru_unit.sv
// Branch, call and return execution unit
`timescale 1ns/1ps
module bcru_unit #(
	parameter logic [23:0] TRAP_VECTOR = bcru_pkg::TRAP_VEC_RST
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Configuration
	input  wire logic              mode_source_pin,
	input  wire logic              ext_frame,
	input  wire logic              exec_internal,
	input  wire logic              dest_internal,
	// Machine state
	input  wire logic [23:0]       pc_in,
	input  wire logic [7:0]        acc,
	input  wire logic [15:0]       data_pointer,
	input  wire logic [23:0]       pop_addr,
	// Request and answer
	input  wire logic              req_valid,
	input  wire bcru_pkg::bcru_req_t req,
	output logic                   rsp_valid,
	output bcru_pkg::bcru_rsp_t    rsp,
	output logic                   mode_source
);
	import bcru_pkg::*;

	logic       mode_s1_q, mode_s2_q, mode_s3_q;
	logic       mode_q;
	logic       mode_arm_q;
	bcru_rsp_t  rsp_q;
	logic       vld_q;

	// Mode strap sampled through three stages after reset
	always_ff @(posedge clk)
	begin
		mode_s1_q <= mode_source_pin;
		mode_s2_q <= mode_s1_q;
		mode_s3_q <= mode_s2_q;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mode_q     <= MODE_RST;
			mode_arm_q <= 1'b1;
		end
		else if (mode_arm_q && (mode_s2_q == mode_s3_q))
		begin
			mode_q     <= mode_s3_q;
			mode_arm_q <= 1'b0;
		end
	end

	wire        src   = mode_q;
	wire        lform = (req.form == FM_LONG);
	wire [7:0]  dec_v = req.opnd1 - 8'h01;

	// Instruction length per opcode map
	logic [2:0] len;
	always_comb
	begin
		case (req.op)
			OP_NOP, OP_IJMP, OP_RET, OP_IRET: len = 3'd1;
			OP_JBS, OP_JBC, OP_JBSC: len = lform ? (src ? 3'd4 : 3'd5) : 3'd3;
			OP_JAZ, OP_JANZ, OP_SHORT_JUMP, OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL: len = 3'd2;
			OP_CMPJ: len = (src && req.form != FM_SHORT) ? 3'd4 : 3'd3;
			OP_DECJ: len = (req.form == FM_REG) ? (src ? 3'd3 : 3'd2) : 3'd3;
			OP_EXTENDED_JUMP, OP_EXTENDED_CALL: len = (req.form == FM_INDIR) ? (src ? 3'd2 : 3'd3) : (src ? 3'd4 : 3'd5);
			OP_LONG_JUMP, OP_LONG_CALL: len = (req.form == FM_INDIR) ? (src ? 3'd2 : 3'd3) : 3'd3;
			OP_EXTENDED_RETURN: len = src ? 3'd2 : 3'd3;
			OP_TRAP: len = src ? 3'd1 : 3'd2;
			default: len = 3'd1;
		endcase
	end

	wire [23:0] pc_adv  = pc_in + {21'h0, len};
	wire [23:0] pc_rel  = pc_adv + {{16{req.rel[7]}}, req.rel};
	wire        cond_op = (req.op inside {OP_JBS, OP_JBC, OP_JBSC, OP_JAZ, OP_JANZ, OP_CMPJ, OP_DECJ});

	logic cond;
	always_comb
	begin
		case (req.op)
			OP_JBS, OP_JBSC: cond = req.opnd_bit;
			OP_JBC:  cond = ~req.opnd_bit;
			OP_JAZ:  cond = (acc == 8'h00);
			OP_JANZ: cond = (acc != 8'h00);
			OP_CMPJ: cond = (req.opnd1 != req.opnd2);
			OP_DECJ: cond = (dec_v != 8'h00);
			default: cond = 1'b0;
		endcase
	end

	logic [23:0] pc_nx;
	always_comb
	begin
		case (req.op)
			OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL: pc_nx = {pc_adv[23:11], req.target[10:0]};
			OP_EXTENDED_JUMP, OP_EXTENDED_CALL: pc_nx = req.target;
			OP_LONG_JUMP, OP_LONG_CALL: pc_nx = {pc_adv[23:16], req.target[15:0]};
			OP_SHORT_JUMP:           pc_nx = pc_rel;
			OP_IJMP:           pc_nx = {PC_PAGE_FF, data_pointer + {8'h00, acc}};
			OP_RET, OP_IRET:   pc_nx = (req.op == OP_IRET && ext_frame) ? pop_addr : {pc_in[23:16], pop_addr[15:0]};
			OP_EXTENDED_RETURN:           pc_nx = pop_addr;
			OP_TRAP:           pc_nx = TRAP_VECTOR;
			default:           pc_nx = cond ? pc_rel : pc_adv;
		endcase
	end

	logic [4:0] st_base;
	always_comb
	begin
		case (req.op)
			OP_JBS, OP_JBC: st_base = lform ? (src ? 5'd3 : 5'd4) : 5'd2;
			OP_JBSC: st_base = lform ? (src ? 5'd6 : 5'd7) : 5'd4;
			OP_JAZ, OP_JANZ: st_base = 5'd2;
			OP_CMPJ: st_base = (req.form == FM_INDIR) ? (src ? 5'd4 : 5'd3)
				: (req.form == FM_REG && src) ? 5'd3 : 5'd2;
			OP_DECJ: st_base = (req.form == FM_REG && !src) ? 5'd2 : 5'd3;
			OP_ABSOLUTE_JUMP: st_base = 5'd3;
			OP_EXTENDED_JUMP: st_base = (req.form == FM_INDIR) ? (src ? 5'd6 : 5'd7) : (src ? 5'd5 : 5'd6);
			OP_LONG_JUMP: st_base = (req.form == FM_INDIR) ? (src ? 5'd5 : 5'd6) : 5'd5;
			OP_SHORT_JUMP: st_base = ST_SHORT_JUMP;
			OP_IJMP: st_base = ST_IJMP;
			OP_ABSOLUTE_CALL: st_base = ST_CALL;
			OP_EXTENDED_CALL: st_base = src ? 5'd13 : 5'd14;
			OP_LONG_CALL: st_base = (req.form == FM_INDIR && !src) ? 5'd10 : ST_CALL;
			OP_RET, OP_IRET: st_base = ST_RET;
			OP_EXTENDED_RETURN: st_base = src ? 5'd8 : 5'd9;
			OP_TRAP: st_base = src ? 5'd11 : 5'd12;
			default: st_base = ST_NOP;
		endcase
	end

	wire taken  = cond_op ? cond : (req.op != OP_NOP);
	wire [4:0] loc_add = (req.op == OP_JBSC) ? ((req.loc == LOC_PORT) ? 5'd3 : (req.loc == LOC_SFR) ? 5'd5 : 5'd0)
		: (req.op == OP_DECJ) ? ((req.loc == LOC_PORT) ? 5'd2 : (req.loc == LOC_SFR) ? 5'd3 : 5'd0)
		: (req.op inside {OP_JBS, OP_JBC, OP_CMPJ}) ? ((req.loc == LOC_PORT) ? 5'd1 : (req.loc == LOC_SFR) ? 5'd2 : 5'd0)
		: 5'd0;
	wire odd_ok = exec_internal && dest_internal && pc_nx[0] && taken
		&& !(req.op inside {OP_TRAP});
	wire uncond = req.op inside {OP_ABSOLUTE_JUMP, OP_EXTENDED_JUMP, OP_LONG_JUMP, OP_SHORT_JUMP, OP_IJMP, OP_ABSOLUTE_CALL, OP_EXTENDED_CALL, OP_LONG_CALL};
	wire [4:0] ext_add = (!uncond || dest_internal) ? 5'd0
		: (req.op inside {OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL, OP_EXTENDED_CALL, OP_LONG_CALL}) ? ST_EXT_ABS : ST_EXT_OTHER;
	wire [4:0] frm_add = ((req.op == OP_IRET || req.op == OP_TRAP) && ext_frame) ? ST_EXT_FRAME : 5'd0;
	wire [4:0] states = st_base + ((cond_op && cond) ? ST_TAKEN_ADD : 5'd0) + loc_add
		+ (odd_ok ? ST_ODD : 5'd0) + ext_add + frm_add;

	bcru_rsp_t rsp_d;
	always_comb
	begin
		rsp_d          = '0;
		rsp_d.pc       = pc_nx;
		rsp_d.taken    = taken;
		rsp_d.states   = states;
		rsp_d.wr_bit   = (req.op == OP_JBSC) && req.opnd_bit;
		rsp_d.wr_byte  = (req.op == OP_DECJ);
		rsp_d.wr_data  = dec_v;
		rsp_d.wr_carry = (req.op == OP_CMPJ);
		rsp_d.carry    = (req.opnd1 < req.opnd2);
		rsp_d.push     = req.op inside {OP_ABSOLUTE_CALL, OP_EXTENDED_CALL, OP_LONG_CALL, OP_TRAP};
		rsp_d.pop      = req.op inside {OP_RET, OP_EXTENDED_RETURN, OP_IRET};
		rsp_d.stk_wide = (req.op inside {OP_EXTENDED_CALL, OP_EXTENDED_RETURN})
			|| ((req.op inside {OP_IRET, OP_TRAP}) && ext_frame);
		rsp_d.stk_psw  = (req.op inside {OP_IRET, OP_TRAP}) && ext_frame;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			vld_q <= 1'b0;
			rsp_q <= '0;
		end
		else
		begin
			vld_q <= req_valid;
			if (req_valid)
				rsp_q <= rsp_d;
		end
	end

	assign rsp_valid   = vld_q;
	assign rsp         = rsp_q;
	assign mode_source = mode_q;

endmodule : bcru_unit

// File: sim/bcru_unit_monitor.sv
// Concurrent checks on the unit ports
`timescale 1ns/1ps
module bcru_unit_monitor #(
	parameter logic [23:0] TRAP_VECTOR = bcru_pkg::TRAP_VEC_RST
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                srst,
	// Machine state
	input wire logic [23:0]         pc_in,
	input wire logic [7:0]          acc,
	input wire logic [15:0]         data_pointer,
	input wire logic [23:0]         pop_addr,
	// Request and answer
	input wire logic                req_valid,
	input wire bcru_pkg::bcru_req_t req,
	input wire logic                rsp_valid,
	input wire bcru_pkg::bcru_rsp_t rsp
);
	import bcru_pkg::*;
	logic        v_q;
	bcru_req_t   r_q;
	logic [23:0] pc_q;
	logic [23:0] pop_q;
	logic [7:0]  acc_q;
	logic [15:0] dp_q;
	// Copy of the request just taken
	always_ff @(posedge clk)
	begin
		v_q   <= req_valid & ~srst;
		r_q   <= req;
		pc_q  <= pc_in;
		pop_q <= pop_addr;
		acc_q <= acc;
		dp_q  <= data_pointer;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	chk_nop_step:
		assert property (v_q && r_q.op == OP_NOP |-> rsp_valid && rsp.pc == pc_q + 24'h1 && rsp.states == 5'h01)
		else $error("nop result wrong");
	chk_ijmp_target:
		assert property (v_q && r_q.op == OP_IJMP |-> rsp.pc == {8'hFF, dp_q + {8'h00, acc_q}})
		else $error("indirect jump target wrong");
	chk_short_jump_target:
		assert property (v_q && r_q.op == OP_SHORT_JUMP |-> rsp.pc == pc_q + 24'h2 + {{16{r_q.rel[7]}}, r_q.rel})
		else $error("short jump target wrong");
	chk_extended_jump_target:
		assert property (v_q && r_q.op == OP_EXTENDED_JUMP |-> rsp.pc == r_q.target)
		else $error("extended jump target wrong");
	chk_acc_zero:
		assert property (v_q && r_q.op == OP_JAZ |-> rsp.taken == (acc_q == 8'h00))
		else $error("zero jump decision wrong");
	chk_compare_carry:
		assert property (v_q && r_q.op == OP_CMPJ |-> rsp.wr_carry && rsp.carry == (r_q.opnd1 < r_q.opnd2)
			&& rsp.taken == (r_q.opnd1 != r_q.opnd2))
		else $error("compare jump wrong");
	chk_decrement_wb:
		assert property (v_q && r_q.op == OP_DECJ |-> rsp.wr_byte && rsp.wr_data == r_q.opnd1 - 8'h01)
		else $error("decrement writeback wrong");
	chk_bit_clear:
		assert property (v_q && r_q.op == OP_JBSC |-> rsp.wr_bit == r_q.opnd_bit && rsp.taken == r_q.opnd_bit)
		else $error("bit clear jump wrong");
	chk_extended_return_pop:
		assert property (v_q && r_q.op == OP_EXTENDED_RETURN |-> rsp.pop && rsp.stk_wide && rsp.pc == pop_q)
		else $error("extended return wrong");
	chk_trap_vector:
		assert property (v_q && r_q.op == OP_TRAP |-> rsp.push && rsp.pc == TRAP_VECTOR)
		else $error("trap vector wrong");
endmodule : bcru_unit_monitor
bind bcru_unit bcru_unit_monitor #(.TRAP_VECTOR(TRAP_VECTOR)) u_mon (.clk, .srst, .pc_in, .acc, .data_pointer,
	.pop_addr, .req_valid, .req, .rsp_valid, .rsp);

// File: sim/bcru_stack_model.sv
// Stack memory model returning the top entry
`timescale 1ns/1ps
module bcru_stack_model (
	// Clock
	input  wire logic        clk,
	// Write side
	input  wire logic        wr,
	input  wire logic [23:0] wdata,
	// Read side
	output logic [23:0]      top
);
	initial top = 24'hA5A5A5;
	always @(posedge clk)
		if (wr)
			top <= wdata;
endmodule : bcru_stack_model

// File: sim/tb_top.sv
// Random self-checking bench for the unit
`timescale 1ns/1ps
module tb_top;
	import bcru_pkg::*;
	logic clk = 0, srst = 1, mode_source_pin = 0, ext_frame = 0, exec_internal = 0, dest_internal = 0;
	logic [23:0] pc_in = 0, pop_addr, stk_d = 0;
	logic [7:0] acc = 0;
	logic [15:0] data_pointer = 0;
	logic req_valid = 0, rsp_valid, mode_source, stk_wr = 0, msrc;
	bcru_req_t req = '0;
	bcru_rsp_t rsp;
	int err_total = 0, checks = 0, seed = 90;
	bcru_op_t ops[$] = '{OP_NOP, OP_JBS, OP_JBC, OP_JBSC, OP_JAZ, OP_JANZ, OP_CMPJ, OP_DECJ, OP_EXTENDED_JUMP, OP_LONG_JUMP,
		OP_SHORT_JUMP, OP_IJMP, OP_EXTENDED_CALL, OP_LONG_CALL, OP_RET, OP_EXTENDED_RETURN, OP_IRET, OP_TRAP, OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL};
	bcru_unit dut (.clk, .srst, .mode_source_pin, .ext_frame, .exec_internal, .dest_internal, .pc_in, .acc,
		.data_pointer, .pop_addr, .req_valid, .req, .rsp_valid, .rsp, .mode_source);
	bcru_stack_model stk (.clk, .wr(stk_wr), .wdata(stk_d), .top(pop_addr));
	always #50 clk = ~clk;
	task automatic cmp(input logic ok, input string what);
		checks++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("Error at %0t: %s mismatch", $time, what);
		end
	endtask : cmp
	task final_report;
		$display("Checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic run(input bcru_op_t op);
		bcru_req_t r;
		logic [23:0] pc, tos, npc, sx;
		logic [15:0] dp;
		logic [7:0] a, st, nt;
		logic tk, ef, xi, di;
		r = '0;
		r.op = op;
		r.form = (op == OP_DECJ) ? FM_REG : FM_SHORT;
		r.loc = bcru_loc_t'(2'($unsigned($random(seed)) % 3));
		r.rel = 8'($random(seed));
		r.target = 24'($random(seed));
		r.opnd_bit = 1'($random(seed));
		r.opnd1 = 8'($random(seed)) & 8'h03;
		r.opnd2 = r.opnd1 ^ (8'($random(seed)) & 8'h01);
		{ef, xi, di} = 3'($random(seed));
		pc = {12'h124, 12'($random(seed))};
		tos = 24'($random(seed));
		dp = 16'($random(seed));
		a = 8'($random(seed)) & 8'h03;
		sx = {{16{r.rel[7]}}, r.rel};
		tk = (op == OP_JBC) ? !r.opnd_bit : (op == OP_JBS || op == OP_JBSC) ? r.opnd_bit : (op == OP_JAZ) ? a == 0 :
			(op == OP_JANZ) ? a != 0 : (op == OP_CMPJ) ? r.opnd1 != r.opnd2 : (op == OP_DECJ) ? r.opnd1 != 8'h01 : 1'b1;
		nt = (op == OP_JBSC) ? 8'h04 : (op == OP_DECJ) ? 8'h02 + 8'(msrc) : 8'h02;
		{npc, st} = {pc + ((op inside {OP_JAZ, OP_JANZ}) ? 24'h2 : (op == OP_DECJ) ? 24'h2 + 24'(msrc) : 24'h3)
			+ (tk ? sx : 24'h0), nt + (tk ? 8'h03 : 8'h00)};
		case (op)
			OP_NOP:   {npc, st} = {pc + 24'h1, 8'h01};
			OP_ABSOLUTE_JUMP:  {npc, st} = {((pc + 24'h2) & 24'hFFF800) | {13'h0, r.target[10:0]}, 8'h03};
			OP_ABSOLUTE_CALL: {npc, st} = {((pc + 24'h2) & 24'hFFF800) | {13'h0, r.target[10:0]}, 8'h09};
			OP_EXTENDED_JUMP:  {npc, st} = {r.target, 8'h06 - 8'(msrc)};
			OP_LONG_JUMP:  {npc, st} = {pc[23:16], r.target[15:0], 8'h05};
			OP_SHORT_JUMP:  {npc, st} = {pc + 24'h2 + sx, 8'h04};
			OP_IJMP:  {npc, st} = {8'hFF, dp + {8'h00, a}, 8'h05};
			OP_EXTENDED_CALL: {npc, st} = {r.target, 8'h0E - 8'(msrc)};
			OP_LONG_CALL: {npc, st} = {pc[23:16], r.target[15:0], 8'h09};
			OP_RET:   {npc, st} = {pc[23:16], tos[15:0], 8'h07};
			OP_EXTENDED_RETURN:  {npc, st} = {tos, 8'h09 - 8'(msrc)};
			OP_IRET:  {npc, st} = {ef ? tos[23:16] : pc[23:16], tos[15:0], ef ? 8'h0C : 8'h07};
			OP_TRAP:  {npc, st} = {TRAP_VEC_RST, (ef ? 8'h11 : 8'h0C) - 8'(msrc)};
			default:  ;
		endcase
		if (r.loc != LOC_RAM)
			st = st + ((op == OP_JBSC) ? ((r.loc == LOC_PORT) ? 8'h03 : 8'h05)
				: (op == OP_DECJ) ? ((r.loc == LOC_PORT) ? 8'h02 : 8'h03)
				: (op inside {OP_JBS, OP_JBC, OP_CMPJ}) ? ((r.loc == LOC_PORT) ? 8'h01 : 8'h02) : 8'h00);
		if (tk && !(op inside {OP_NOP, OP_TRAP}) && xi && di && npc[0])
			st = st + 8'h01;
		if (!di && op inside {OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL, OP_EXTENDED_JUMP, OP_LONG_JUMP, OP_SHORT_JUMP, OP_IJMP, OP_EXTENDED_CALL, OP_LONG_CALL})
			st = st + ((op inside {OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL, OP_EXTENDED_CALL, OP_LONG_CALL}) ? 8'h02 : 8'h03);
		@(posedge clk);
		stk_wr <= 1'b1;
		stk_d <= tos;
		@(posedge clk);
		stk_wr <= 1'b0;
		{req_valid, req, pc_in, acc, data_pointer, ext_frame, exec_internal, dest_internal} <= {1'b1, r, pc, a, dp, ef, xi, di};
		@(posedge clk);
		req_valid <= 1'b0;
		@(negedge clk);
		cmp(rsp_valid === 1'b1 && rsp.pc === npc, "program counter");
		cmp(rsp.states === st[4:0], "state count");
		cmp(rsp.taken === tk || !(op inside {OP_JBS, OP_JBC, OP_JAZ, OP_JANZ, OP_DECJ}), "branch decision");
		cmp({rsp.push, rsp.pop} === {op inside {OP_ABSOLUTE_CALL, OP_EXTENDED_CALL, OP_LONG_CALL, OP_TRAP}, op inside {OP_RET, OP_EXTENDED_RETURN, OP_IRET}},
			"stack traffic");
	endtask : run
	initial
	begin
		for (int m = 0; m < 2; m++)
		begin
			msrc = m[0];
			@(posedge clk);
			srst <= 1'b1;
			mode_source_pin <= m[0];
			repeat (20) @(posedge clk);
			srst <= 1'b0;
			repeat (4) @(posedge clk);
			cmp(mode_source === msrc, "mode latch");
			for (int i = 0; i < 300; i++)
				run(ops[$unsigned($random(seed)) % ops.size()]);
			$display("Mode %0d sequence done", m);
		end
		final_report;
	end
	initial
	begin
		#2000000;
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		final_report;
	end
endmodule : tb_top
